// ==== mav_map.vh ====
`ifndef MAV_MAP_VH
`define MAV_MAP_VH

// ==========================================================
// Opcodes handled by the addressing engine
`define MAV_OP_SUPERVISORY_CALL 8'h00
`define MAV_OP_IND_LOAD 8'h3E
`define MAV_OP_IND_STORE 8'h3F
`define MAV_OP_NOP 8'h40
`define MAV_OP_MOV_A_IMM 8'h50
`define MAV_OP_MOV_A_DIR 8'h51
`define MAV_OP_MOV_DIR_IMM 8'h55
`define MAV_OP_MOV_IDX_IMM 8'h56
`define MAV_OP_MOV_X_IMM 8'h57
`define MAV_OP_MOV_MEM_MEM 8'h5F
`define MAV_OP_LJMP 8'h7D
`define MAV_OP_RETI 8'h7E

// ==========================================================
// Nominal cycle counts
`define MAV_CYC_SUPERVISORY_CALL 5'h0F
`define MAV_CYC_IND_MOVE 5'h0A
`define MAV_CYC_NOP 5'h04
`define MAV_CYC_MOV_A_IMM 5'h04
`define MAV_CYC_MOV_A_DIR 5'h05
`define MAV_CYC_MOV_DIR_IMM 5'h08
`define MAV_CYC_MOV_IDX_IMM 5'h09
`define MAV_CYC_MOV_X_IMM 5'h04
`define MAV_CYC_MOV_MEM_MEM 5'h0A
`define MAV_CYC_LJMP 5'h07
`define MAV_CYC_RETI 5'h0A
`define MAV_CYC_IRQ 5'h0D

// ==========================================================
// Instruction lengths in bytes
`define MAV_LEN_1 2'h1
`define MAV_LEN_2 2'h2
`define MAV_LEN_3 2'h3

// ==========================================================
// Program memory layout
`define MAV_RESET_PC 16'h0000
`define MAV_VEC_BASE 16'h0004
`define MAV_VEC_LAST_IDX 5'h18
`define MAV_PM_MASK 16'h1FFF
`define MAV_PTR_STEP 8'h01

// ==========================================================
// Flash rows
`define MAV_AUX_ROW_BASE 8'h80
`define MAV_AUX_ROW_COUNT 8'h04

`endif

// ==== mav_flash_gate.v ====
`timescale 1ns/1ns
`include "mav_map.vh"

module mav_flash_gate #(
	parameter PROG_ENTRY_CYCLES = 16
) (
	// Clock and reset
	input wire CLK,
	input wire RESETN,
	// Core state
	input wire IN_SUPERVISORY_ROM,
	// Flash control register access
	input wire FLASH_REG_SEL,
	output wire FLASH_REG_EN,
	// Whole-device erase
	input wire ERASE_ALL_REQ,
	input wire [7:0] ERASE_ROW,
	output wire ERASE_ROW_EN,
	// USB data pins
	input wire DP_IN,
	input wire DM_IN,
	output wire PROG_MODE
);
	reg dp_s1_reg;
	reg dp_s2_reg;
	reg dm_s1_reg;
	reg dm_s2_reg;
	reg [15:0] entry_cnt_reg;
	reg prog_mode_reg;
	wire row_is_aux;

	// ==========================================================
	// Flash control visibility
	// User code never sees these registers, so flash changes go through the ROM calls.
	assign FLASH_REG_EN = FLASH_REG_SEL & IN_SUPERVISORY_ROM;

	// ==========================================================
	// Auxiliary rows survive a whole-device erase
	assign row_is_aux = (ERASE_ROW >= `MAV_AUX_ROW_BASE) &&
		(ERASE_ROW < `MAV_AUX_ROW_BASE + `MAV_AUX_ROW_COUNT);
	assign ERASE_ROW_EN = ERASE_ALL_REQ & ~row_is_aux;

	// ==========================================================
	// Serial programming entry
	// Both data pins high is never a valid USB line state, so it cannot be hit by traffic.
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dp_s1_reg <= 1'b0;
			dp_s2_reg <= 1'b0;
			dm_s1_reg <= 1'b0;
			dm_s2_reg <= 1'b0;
			entry_cnt_reg <= 16'h0000;
			prog_mode_reg <= 1'b0;
		end else begin
			dp_s1_reg <= DP_IN;
			dp_s2_reg <= dp_s1_reg;
			dm_s1_reg <= DM_IN;
			dm_s2_reg <= dm_s1_reg;
			if (!(dp_s2_reg & dm_s2_reg)) begin
				entry_cnt_reg <= 16'h0000;
			end else if (entry_cnt_reg == PROG_ENTRY_CYCLES[15:0] - 16'h0001) begin
				prog_mode_reg <= 1'b1;
			end else begin
				entry_cnt_reg <= entry_cnt_reg + 16'h0001;
			end
		end
	end

	assign PROG_MODE = prog_mode_reg;
endmodule // mav_flash_gate

// ==== mav_core.v ====
`timescale 1ns/1ns
`include "mav_map.vh"

module mav_core #(
	parameter RAM_DEPTH = 256,
	parameter PROG_ENTRY_CYCLES = 16
) (
	// Clock and reset
	input wire CLK,
	input wire RESETN,
	// Program memory, asynchronous read
	output wire [15:0] PM_ADDR,
	input wire [7:0] PM_DATA,
	// Interrupts
	input wire IRQ_REQ,
	input wire [4:0] IRQ_NUM,
	input wire IRQ_GLOBAL_EN,
	output wire IRQ_ACK,
	// Status
	output wire [15:0] PC,
	output wire [7:0] ACC,
	output wire [7:0] IDX,
	output wire INSTR_DONE,
	output wire ILLEGAL_OP,
	output wire IN_SUPERVISORY_ROM,
	// Flash access
	input wire FLASH_REG_SEL,
	output wire FLASH_REG_EN,
	input wire ERASE_ALL_REQ,
	input wire [7:0] ERASE_ROW,
	output wire ERASE_ROW_EN,
	// USB data pins
	input wire DP_IN,
	input wire DM_IN,
	output wire PROG_MODE
);
	localparam S_FETCH = 3'b000;
	localparam S_OPC = 3'b001;
	localparam S_OP1 = 3'b010;
	localparam S_OP2 = 3'b011;
	localparam S_EXEC = 3'b100;
	localparam S_PINC = 3'b101;
	localparam S_WAIT = 3'b110;
	localparam S_IRQ = 3'b111;

	reg [7:0] ram [0:RAM_DEPTH-1];
	reg [2:0] state_reg;
	reg [15:0] pc_reg;
	reg [15:0] npc_reg;
	reg [15:0] pm_addr_reg;
	reg [7:0] op_reg;
	reg [7:0] op1_reg;
	reg [7:0] op2_reg;
	reg [7:0] a_reg;
	reg [7:0] x_reg;
	reg [7:0] ptr_reg;
	reg [4:0] cnt_reg;
	reg [4:0] total_reg;
	reg [1:0] len_reg;
	reg [4:0] vec_reg;
	reg in_rom_reg;
	reg done_reg;
	reg ack_reg;
	reg illegal_reg;
	reg ram_we;
	reg [7:0] ram_wa;
	reg [7:0] ram_wd;
	wire [15:0] last_byte;
	wire [15:0] seq_pc;
	wire [7:0] ptr_now;
	wire irq_take;

	// ==========================================================
	// Decode helpers
	function [1:0] len_of;
		input [7:0] op;
		begin
			case (op)
				`MAV_OP_IND_LOAD, `MAV_OP_IND_STORE: len_of = `MAV_LEN_2;
				`MAV_OP_MOV_A_IMM, `MAV_OP_MOV_A_DIR, `MAV_OP_MOV_X_IMM: len_of = `MAV_LEN_2;
				`MAV_OP_MOV_DIR_IMM, `MAV_OP_LJMP: len_of = `MAV_LEN_3;
				`MAV_OP_MOV_IDX_IMM, `MAV_OP_MOV_MEM_MEM: len_of = `MAV_LEN_3;
				default: len_of = `MAV_LEN_1;
			endcase
		end
	endfunction

	function [4:0] cyc_of;
		input [7:0] op;
		begin
			case (op)
				`MAV_OP_SUPERVISORY_CALL: cyc_of = `MAV_CYC_SUPERVISORY_CALL;
				`MAV_OP_IND_LOAD, `MAV_OP_IND_STORE: cyc_of = `MAV_CYC_IND_MOVE;
				`MAV_OP_MOV_A_IMM: cyc_of = `MAV_CYC_MOV_A_IMM;
				`MAV_OP_MOV_A_DIR: cyc_of = `MAV_CYC_MOV_A_DIR;
				`MAV_OP_MOV_DIR_IMM: cyc_of = `MAV_CYC_MOV_DIR_IMM;
				`MAV_OP_MOV_IDX_IMM: cyc_of = `MAV_CYC_MOV_IDX_IMM;
				`MAV_OP_MOV_X_IMM: cyc_of = `MAV_CYC_MOV_X_IMM;
				`MAV_OP_MOV_MEM_MEM: cyc_of = `MAV_CYC_MOV_MEM_MEM;
				`MAV_OP_LJMP: cyc_of = `MAV_CYC_LJMP;
				`MAV_OP_RETI: cyc_of = `MAV_CYC_RETI;
				default: cyc_of = `MAV_CYC_NOP;
			endcase
		end
	endfunction

	function is_known;
		input [7:0] op;
		begin
			case (op)
				`MAV_OP_SUPERVISORY_CALL, `MAV_OP_IND_LOAD, `MAV_OP_IND_STORE, `MAV_OP_NOP,
				`MAV_OP_MOV_A_IMM, `MAV_OP_MOV_A_DIR, `MAV_OP_MOV_DIR_IMM, `MAV_OP_MOV_IDX_IMM,
				`MAV_OP_MOV_X_IMM, `MAV_OP_MOV_MEM_MEM, `MAV_OP_LJMP, `MAV_OP_RETI: is_known = 1'b1;
				default: is_known = 1'b0;
			endcase
		end
	endfunction

	// ==========================================================
	// Page crossing and sequential address
	assign last_byte = pc_reg + {14'h0000, len_of(PM_DATA)} - 16'h0001;
	assign seq_pc = (pc_reg + {14'h0000, len_reg}) & `MAV_PM_MASK;
	assign ptr_now = ram[op1_reg];
	assign irq_take = IRQ_REQ & IRQ_GLOBAL_EN & (IRQ_NUM <= `MAV_VEC_LAST_IDX);

	// ==========================================================
	// Data RAM write port
	// One write port only, so the indirect forms spend a second cycle on the pointer update.
	always @* begin
		ram_we = 1'b0;
		ram_wa = 8'h00;
		ram_wd = 8'h00;
		if (state_reg == S_EXEC) begin
			case (op_reg)
				`MAV_OP_MOV_DIR_IMM: begin
					ram_we = 1'b1;
					ram_wa = op1_reg;
					ram_wd = op2_reg;
				end
				`MAV_OP_MOV_IDX_IMM: begin
					ram_we = 1'b1;
					ram_wa = op1_reg + x_reg;
					ram_wd = op2_reg;
				end
				`MAV_OP_MOV_MEM_MEM: begin
					ram_we = 1'b1;
					ram_wa = op1_reg;
					ram_wd = ram[op2_reg];
				end
				`MAV_OP_IND_STORE: begin
					ram_we = 1'b1;
					ram_wa = ptr_now;
					ram_wd = a_reg;
				end
				default: begin
					ram_we = 1'b0;
				end
			endcase
		end else if (state_reg == S_PINC) begin
			ram_we = 1'b1;
			ram_wa = op1_reg;
			ram_wd = ptr_reg + `MAV_PTR_STEP;
		end
	end

	always @(posedge CLK) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

	// ==========================================================
	// Sequencer
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= S_FETCH;
			pc_reg <= `MAV_RESET_PC;
			npc_reg <= `MAV_RESET_PC;
			pm_addr_reg <= `MAV_RESET_PC;
			op_reg <= `MAV_OP_NOP;
			op1_reg <= 8'h00;
			op2_reg <= 8'h00;
			a_reg <= 8'h00;
			x_reg <= 8'h00;
			ptr_reg <= 8'h00;
			cnt_reg <= 5'h00;
			total_reg <= `MAV_CYC_NOP;
			len_reg <= `MAV_LEN_1;
			vec_reg <= 5'h00;
			in_rom_reg <= 1'b0;
			done_reg <= 1'b0;
			ack_reg <= 1'b0;
			illegal_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			ack_reg <= 1'b0;
			illegal_reg <= 1'b0;
			cnt_reg <= cnt_reg + 5'h01;
			case (state_reg)
				S_FETCH: begin
					pm_addr_reg <= pc_reg;
					cnt_reg <= 5'h00;
					state_reg <= S_OPC;
				end
				S_OPC: begin
					op_reg <= PM_DATA;
					len_reg <= len_of(PM_DATA);
					illegal_reg <= ~is_known(PM_DATA);
					if (last_byte[15:8] != pc_reg[15:8]) begin
						total_reg <= cyc_of(PM_DATA) + 5'h01;
					end else begin
						total_reg <= cyc_of(PM_DATA);
					end
					pm_addr_reg <= (pc_reg + 16'h0001) & `MAV_PM_MASK;
					state_reg <= (len_of(PM_DATA) == `MAV_LEN_1) ? S_EXEC : S_OP1;
				end
				S_OP1: begin
					op1_reg <= PM_DATA;
					pm_addr_reg <= (pc_reg + 16'h0002) & `MAV_PM_MASK;
					state_reg <= (len_reg == `MAV_LEN_3) ? S_OP2 : S_EXEC;
				end
				S_OP2: begin
					op2_reg <= PM_DATA;
					state_reg <= S_EXEC;
				end
				S_EXEC: begin
					npc_reg <= seq_pc;
					state_reg <= S_WAIT;
					case (op_reg)
						`MAV_OP_SUPERVISORY_CALL: in_rom_reg <= 1'b1;
						`MAV_OP_RETI: in_rom_reg <= 1'b0;
						`MAV_OP_MOV_A_IMM: a_reg <= op1_reg;
						`MAV_OP_MOV_A_DIR: a_reg <= ram[op1_reg];
						`MAV_OP_MOV_X_IMM: x_reg <= op1_reg;
						`MAV_OP_LJMP: npc_reg <= {op1_reg, op2_reg} & `MAV_PM_MASK;
						`MAV_OP_IND_LOAD: begin
							a_reg <= ram[ptr_now];
							ptr_reg <= ptr_now;
							state_reg <= S_PINC;
						end
						`MAV_OP_IND_STORE: begin
							ptr_reg <= ptr_now;
							state_reg <= S_PINC;
						end
						default: begin
							npc_reg <= seq_pc;
						end
					endcase
				end
				S_PINC: begin
					state_reg <= S_WAIT;
				end
				S_WAIT: begin
					// The next opcode address is loaded here so that its fetch overlaps the
					// done cycle; otherwise two-byte four-cycle forms could not meet their count.
					if (cnt_reg == total_reg - 5'h01) begin
						pc_reg <= npc_reg;
						pm_addr_reg <= npc_reg;
						vec_reg <= IRQ_NUM;
						done_reg <= 1'b1;
						cnt_reg <= 5'h00;
						state_reg <= irq_take ? S_IRQ : S_OPC;
					end
				end
				S_IRQ: begin
					if (cnt_reg == `MAV_CYC_IRQ - 5'h01) begin
						// The index latched when the request was taken keeps a source that changes
						// its number during entry from redirecting the vector.
						pc_reg <= `MAV_VEC_BASE + {9'h000, vec_reg, 2'h0};
						ack_reg <= 1'b1;
						state_reg <= S_FETCH;
					end
				end
				default: begin
					state_reg <= S_FETCH;
				end
			endcase
		end
	end

	// ==========================================================
	// Flash access gate and serial programming entry
	mav_flash_gate #(
		.PROG_ENTRY_CYCLES(PROG_ENTRY_CYCLES)
	) u_gate (
		.CLK(CLK),
		.RESETN(RESETN),
		.IN_SUPERVISORY_ROM(in_rom_reg),
		.FLASH_REG_SEL(FLASH_REG_SEL),
		.FLASH_REG_EN(FLASH_REG_EN),
		.ERASE_ALL_REQ(ERASE_ALL_REQ),
		.ERASE_ROW(ERASE_ROW),
		.ERASE_ROW_EN(ERASE_ROW_EN),
		.DP_IN(DP_IN),
		.DM_IN(DM_IN),
		.PROG_MODE(PROG_MODE)
	);

	assign PM_ADDR = pm_addr_reg;
	assign PC = pc_reg;
	assign ACC = a_reg;
	assign IDX = x_reg;
	assign INSTR_DONE = done_reg;
	assign IRQ_ACK = ack_reg;
	assign ILLEGAL_OP = illegal_reg;
	assign IN_SUPERVISORY_ROM = in_rom_reg;
endmodule // mav_core

// ==== mav_core_chk.sv ====
`timescale 1ns/1ns
module mav_core_chk #(
	parameter PROG_ENTRY_CYCLES = 16
) (
	// Clock and reset
	input logic CLK,
	input logic RESETN,
	// Core status
	input logic [15:0] PM_ADDR,
	input logic [15:0] PC,
	input logic INSTR_DONE,
	input logic ILLEGAL_OP,
	input logic IN_SUPERVISORY_ROM,
	// Interrupts
	input logic IRQ_REQ,
	input logic [4:0] IRQ_NUM,
	input logic IRQ_GLOBAL_EN,
	input logic IRQ_ACK,
	// Flash and programming
	input logic FLASH_REG_SEL,
	input logic FLASH_REG_EN,
	input logic ERASE_ALL_REQ,
	input logic [7:0] ERASE_ROW,
	input logic ERASE_ROW_EN,
	input logic DP_IN,
	input logic DM_IN,
	input logic PROG_MODE
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	// A request counts only in the last wait cycle, one cycle before the done pulse.
	wire take = IRQ_REQ && IRQ_GLOBAL_EN && IRQ_NUM <= 5'h18;
	AST_RESET_FETCH: assert property ($past(!RESETN) |-> PM_ADDR == 16'h0000)
		else $error("first fetch not at zero");
	AST_IRQ_LATENCY: assert property (INSTR_DONE && $past(take) |-> ##13 IRQ_ACK)
		else $error("interrupt entry not 13 cycles");
	AST_IRQ_HELD: assert property (INSTR_DONE && !$past(take) |-> ##13 !IRQ_ACK)
		else $error("interrupt taken without request");
	AST_VECTOR: assert property (IRQ_ACK |-> PC == 16'h0004 + {9'h000, $past(IRQ_NUM, 14), 2'h0})
		else $error("wrong vector address");
	AST_FLASH_GATE: assert property (FLASH_REG_EN == (FLASH_REG_SEL && IN_SUPERVISORY_ROM))
		else $error("flash registers reachable outside ROM");
	AST_AUX_ROWS: assert property (ERASE_ROW_EN == (ERASE_ALL_REQ && ERASE_ROW[7:2] != 6'h20))
		else $error("auxiliary row erase gating wrong");
	AST_PROG_STICKY: assert property (PROG_MODE |=> PROG_MODE)
		else $error("programming mode dropped");
	AST_PROG_ENTRY: assert property ($rose(PROG_MODE) |-> $past(DP_IN && DM_IN, 4))
		else $error("programming mode without pin pattern");
	AST_ILLEGAL_NOP: assert property (ILLEGAL_OP |-> ##[1:3] INSTR_DONE)
		else $error("unknown opcode not run as short nop");
	AST_PC_SPACE: assert property (PC <= 16'h1FFF)
		else $error("program counter beyond 8 KB");
	AST_DONE_GAP: assert property (INSTR_DONE |=> !INSTR_DONE [*3])
		else $error("instruction shorter than four cycles");
	cover property (IRQ_ACK);
	cover property ($rose(PROG_MODE));
	cover property (ILLEGAL_OP);
endmodule // mav_core_chk

bind mav_core mav_core_chk #(.PROG_ENTRY_CYCLES(PROG_ENTRY_CYCLES)) chk_u (.CLK(CLK),
	.RESETN(RESETN), .PM_ADDR(PM_ADDR), .PC(PC), .INSTR_DONE(INSTR_DONE), .ILLEGAL_OP(ILLEGAL_OP),
	.IN_SUPERVISORY_ROM(IN_SUPERVISORY_ROM), .IRQ_REQ(IRQ_REQ), .IRQ_NUM(IRQ_NUM),
	.IRQ_GLOBAL_EN(IRQ_GLOBAL_EN), .IRQ_ACK(IRQ_ACK), .FLASH_REG_SEL(FLASH_REG_SEL),
	.FLASH_REG_EN(FLASH_REG_EN), .ERASE_ALL_REQ(ERASE_ALL_REQ), .ERASE_ROW(ERASE_ROW),
	.ERASE_ROW_EN(ERASE_ROW_EN), .DP_IN(DP_IN), .DM_IN(DM_IN), .PROG_MODE(PROG_MODE));

// ==== mav_core_tb.sv ====
`timescale 1ns/1ns
module mav_core_tb;
	// ==========
	// Bench signals
	localparam [263:0] PROG = 264'h570556_10AA5F_201551_205530_FF55FF_153EFF_50773F_FF51FF_3E3051_30062F_7D00FF;
	reg clk = 1'b0, resetn = 1'b0, irq_req = 1'b0, irq_en = 1'b0, sel = 1'b0, erase = 1'b0;
	reg dp = 1'b0, dm = 1'b0;
	reg [4:0] irq_num = 5'h00;
	reg [7:0] row = 8'h00;
	wire [15:0] pm_addr, pc_o;
	wire [7:0] acc, idx;
	wire ack, done, ill, in_sup, prog, fen, een;
	reg [7:0] pm [0:8191];
	reg [7:0] ram [0:255];
	reg [7:0] a, x, op, o1, o2, p, lc;
	reg [15:0] pc = 16'h0000, last;
	integer err_total = 0, compares = 0, seed = 45399, i, n, cyc, len, ills = 0, first = 1;
	always #50 clk = ~clk;
	mav_core #(.PROG_ENTRY_CYCLES(4)) dut_u (.CLK(clk), .RESETN(resetn), .PM_ADDR(pm_addr),
		.PM_DATA(pm[pm_addr[12:0]]), .IRQ_REQ(irq_req), .IRQ_NUM(irq_num), .IRQ_GLOBAL_EN(irq_en),
		.IRQ_ACK(ack), .PC(pc_o), .ACC(acc), .IDX(idx), .INSTR_DONE(done), .ILLEGAL_OP(ill),
		.IN_SUPERVISORY_ROM(in_sup), .FLASH_REG_SEL(sel), .FLASH_REG_EN(fen), .ERASE_ALL_REQ(erase),
		.ERASE_ROW(row), .ERASE_ROW_EN(een), .DP_IN(dp), .DM_IN(dm), .PROG_MODE(prog));
	always @(negedge clk) begin
		check("flash enable", fen, sel & in_sup);
		check("erase enable", een, erase & (row[7:2] != 6'h20));
		sel = $random(seed);
		erase = $random(seed);
		row = $random(seed);
	end
	always @(posedge clk) if (ill === 1'b1) ills = ills + 1;
	// ==========
	// Checking and reference model
	task check(input string nm, input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("Error %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task step;
		begin
			op = pm[pc[12:0]];
			o1 = pm[pc[12:0] + 13'h1];
			o2 = pm[pc[12:0] + 13'h2];
			p = ram[o1];
			case (op)
				8'h50, 8'h57: lc = 8'h24;
				8'h51: lc = 8'h25;
				8'h55: lc = 8'h38;
				8'h56: lc = 8'h39;
				8'h5F: lc = 8'h3A;
				8'h3E, 8'h3F: lc = 8'h2A;
				8'h7D: lc = 8'h37;
				8'h00: lc = 8'h1F;
				8'h7E: lc = 8'h1A;
				default: lc = 8'h14;
			endcase
			case (op)
				8'h50: a = o1;
				8'h57: x = o1;
				8'h51: a = ram[o1];
				8'h55: ram[o1] = o2;
				8'h56: ram[o1 + x] = o2;
				8'h5F: ram[o1] = ram[o2];
				8'h3E: a = ram[p];
				8'h3F: ram[p] = a;
				default: ;
			endcase
			if (op == 8'h3E || op == 8'h3F) ram[o1] = p + 8'h01;
			len = lc[7:4];
			cyc = lc[3:0];
			last = pc + len - 1;
			if (last[15:8] != pc[15:8]) cyc = cyc + 1;
			pc = (op == 8'h7D) ? {o1, o2} & 16'h1FFF : (pc + len) & 16'h1FFF;
		end
	endtask
	task wait_for(input integer is_ack);
		begin
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n = n + 1;
			end while ((is_ack ? ack : done) !== 1'b1 && n < 40);
		end
	endtask
	task run(input integer k);
		repeat (k) begin
			step;
			wait_for(0);
			if (!first) check("cycles", n, cyc);
			check("pc", pc_o, pc);
			check("acc", acc, a);
			check("idx", idx, x);
			first = 0;
		end
	endtask
	task irq(input [4:0] num);
		begin
			@(negedge clk);
			irq_num = num;
			irq_req = 1'b1;
			run(1);
			wait_for(1);
			check("irq cycles", n, 13);
			check("vector", pc_o, 16'h0004 + 4 * num);
			@(negedge clk);
			irq_req = 1'b0;
			pc = 16'h0004 + 4 * num;
			first = 1;
		end
	endtask
	task print_verdict;
		begin
			$display("Compares %0d errors %0d", compares, err_total);
			if (err_total == 0 && compares > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	// ==========
	// Main sequence
	initial begin
		for (i = 0; i < 8192; i = i + 1) pm[i] = 8'h40;
		for (i = 0; i < 33; i = i + 1) pm[i] = PROG[263 - 8 * i -: 8];
		pm[255] = 8'h57;
		pm[256] = 8'h33;
		pm[257] = 8'h00;
		pm[258] = 8'h7E;
		repeat (5) @(negedge clk);
		check("reset pc", pc_o, 16'h0000);
		resetn = 1'b1;
		run(17);
		check("illegal", ills, 2);
		check("supervisory", in_sup, 1'b1);
		run(1);
		check("supervisory", in_sup, 1'b0);
		@(negedge clk);
		irq_req = 1'b1;
		irq_num = 5'h05;
		run(2);
		@(negedge clk);
		irq_num = 5'h19;
		irq_en = 1'b1;
		run(2);
		irq(5'h18);
		repeat (3) irq($unsigned($random(seed)) % 25);
		// A short burst must not count toward the entry pattern.
		{dp, dm} = 2'h3;
		repeat (2) @(negedge clk);
		{dp, dm} = 2'h0;
		repeat (10) @(negedge clk);
		check("prog mode", prog, 1'b0);
		{dp, dm} = 2'h3;
		repeat (10) @(negedge clk);
		check("prog mode", prog, 1'b1);
		print_verdict;
	end
	initial begin
		#300000;
		err_total = err_total + 1;
		print_verdict;
	end
endmodule // mav_core_tb
